// File: rtl/xapc_ctrl.sv
`default_nettype none
// ==========================================================================
module xapc_ctrl #(
  parameter int ONCHIP_SIZE     = 4096,
  parameter int STROBE_CYCLES   = xapc_pkg::STROBE_CYCLES_DEF,
  parameter int FIFO_MIN_CYCLES = xapc_pkg::FIFO_MIN_CYCLES_DEF
) (
  input  wire logic                 clk_i,        // system_clock
  input  wire logic                 sys_rst_i,    // Sync reset, high
  input  wire logic                 ce_i,         // Clock enable
  // Special register port
  input  wire logic [7:0]           sfr_addr_i,   // Register address
  input  wire logic                 sfr_wr_i,     // Write strobe
  input  wire logic                 sfr_rd_i,     // Read strobe
  input  wire logic [7:0]           sfr_wdata_i,  // Write data
  output logic [7:0]                sfr_rdata_o,  // Read data, registered
  // Core move request
  input  wire logic                 req_i,        // Start a move
  input  wire xapc_pkg::xapc_req_s  req_data_i,   // Move details
  output logic                      busy_o,       // Move in progress
  output logic                      done_o,       // Move complete pulse
  output logic [7:0]                rdata_o,      // Read result
  output logic [1:0]                target_o,     // Last target taken
  // On-chip RAM
  output logic                      ram_req_o,    // Access strobe
  output logic                      ram_we_o,     // Write
  output logic [15:0]               ram_addr_o,   // Address
  output logic [7:0]                ram_wdata_o,  // Write data
  input  wire logic [7:0]           ram_rdata_i,  // Read data
  // Fifo RAM bridge
  output logic                      fifo_req_o,   // Access request
  output logic                      fifo_we_o,    // Write
  output logic [9:0]                fifo_addr_o,  // Window offset
  output logic [7:0]                fifo_wdata_o, // Write data
  input  wire logic                 fifo_ack_i,   // Access finished
  input  wire logic [7:0]           fifo_rdata_i, // Read data
  // Port pins
  input  wire xapc_pkg::xapc_pins_s port_latch_i, // Port latch values
  input  wire xapc_pkg::xapc_pins_s port_oe_i,    // Crossbar enables
  input  wire xapc_pkg::xapc_pins_s pin_i,        // Pin levels
  output xapc_pkg::xapc_pins_s      pin_o,        // Pin drive value
  output xapc_pkg::xapc_pins_s      pin_oe_o      // Pin drive enable
);

  // ========================================================================
  // Parameter checks
  // A fifo move must outlast an on-chip move, so one cycle is refused
  if (STROBE_CYCLES < 1 || STROBE_CYCLES > 7 ||
      FIFO_MIN_CYCLES <= xapc_pkg::RAM_CYCLES || FIFO_MIN_CYCLES > 7 ||
      ONCHIP_SIZE < 1 || ONCHIP_SIZE > 65536) begin : g_chk
    $error("xapc_ctrl: parameter out of range");
  end

  localparam logic [2:0] STRB_LAST = 3'(STROBE_CYCLES - 1);
  localparam logic [2:0] FIFO_LAST = 3'(FIFO_MIN_CYCLES - 1);
  localparam logic [16:0] ONCHIP_END = 17'(ONCHIP_SIZE);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RAM  = 3'b001,
    ST_FIFO = 3'b010,
    ST_ALE  = 3'b011,
    ST_HOLD = 3'b100,
    ST_STRB = 3'b101,
    ST_DONE = 3'b110
  } xapc_state_e;

  xapc_state_e state_q;
  logic [7:0]  page_q;
  logic [7:0]  cfg_q;
  logic [15:0] dp_q;
  logic [15:0] addr_q;
  logic        write_q;
  logic [7:0]  wdata_q;
  logic [7:0]  rdata_q;
  logic [7:0]  sfr_rdata_q;
  logic [2:0]  cnt_q;
  logic [1:0]  tgt_q;
  logic [15:0] req_addr;
  logic [1:0]  req_tgt;
  logic        claimed;
  logic        nonmux;
  logic [2:0]  ale_last;

  // ========================================================================
  // Address decode, used only for the request target
  function automatic logic [1:0] decode(input logic [15:0] a,
                                        input logic [7:0] cfg,
                                        input logic flash);
    logic [1:0] m;
    m = cfg[xapc_pkg::CFG_MODE_LSB +: 2];
    if (flash) begin
      decode = xapc_pkg::XAPC_TGT_FLASH;
    end else if (cfg[xapc_pkg::CFG_FIFO_EN_BIT] && a >= xapc_pkg::FIFO_LO &&
                 a <= xapc_pkg::FIFO_HI) begin
      decode = xapc_pkg::XAPC_TGT_FIFO;
    end else if (m == xapc_pkg::XAPC_MODE_ONCHIP) begin
      decode = xapc_pkg::XAPC_TGT_RAM;
    end else if (m == xapc_pkg::XAPC_MODE_OFF) begin
      decode = xapc_pkg::XAPC_TGT_OFF;
    end else begin
      decode = ({1'b0, a} < ONCHIP_END) ? xapc_pkg::XAPC_TGT_RAM
                                        : xapc_pkg::XAPC_TGT_OFF;
    end
  endfunction

  // Effective address of the two move forms
  assign req_addr = req_data_i.ptr_form ? dp_q
                                        : {page_q, req_data_i.index};
  assign req_tgt  = decode(req_addr, cfg_q, req_data_i.flash);
  assign nonmux   = cfg_q[xapc_pkg::CFG_NONMUX_BIT];
  assign ale_last = {1'b0, cfg_q[xapc_pkg::CFG_ALE_LSB +: 2]};

  // ========================================================================
  // Special registers; core writes win over nothing, no hardware setters
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      page_q <= xapc_pkg::RST_PAGE;
      cfg_q  <= xapc_pkg::RST_CFG;
      dp_q   <= xapc_pkg::RST_DP;
    end else if (ce_i && sfr_wr_i) begin
      unique case (sfr_addr_i)
        xapc_pkg::ADDR_PAGE:  page_q <= sfr_wdata_i;
        xapc_pkg::ADDR_CFG:   cfg_q  <= sfr_wdata_i & xapc_pkg::CFG_WMASK;
        xapc_pkg::ADDR_DP_LO: dp_q[7:0]  <= sfr_wdata_i;
        xapc_pkg::ADDR_DP_HI: dp_q[15:8] <= sfr_wdata_i;
        default: ;
      endcase
    end
  end

  // Register read data; unmapped addresses read zero
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sfr_rdata_q <= 8'h00_00;
    end else if (ce_i && sfr_rd_i) begin
      unique case (sfr_addr_i)
        xapc_pkg::ADDR_PAGE:  sfr_rdata_q <= page_q;
        xapc_pkg::ADDR_CFG:   sfr_rdata_q <= cfg_q;
        xapc_pkg::ADDR_DP_LO: sfr_rdata_q <= dp_q[7:0];
        xapc_pkg::ADDR_DP_HI: sfr_rdata_q <= dp_q[15:8];
        default:              sfr_rdata_q <= 8'h00_00;
      endcase
    end
  end

  // ========================================================================
  // Move sequencer
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_q <= ST_IDLE;
      cnt_q   <= 3'h0;
    end else if (ce_i) begin
      unique case (state_q)
        ST_IDLE: begin
          cnt_q <= 3'h0;
          if (req_i) begin
            unique case (req_tgt)
              xapc_pkg::XAPC_TGT_RAM:  state_q <= ST_RAM;
              xapc_pkg::XAPC_TGT_FIFO: state_q <= ST_FIFO;
              xapc_pkg::XAPC_TGT_OFF:  state_q <= nonmux ? ST_STRB : ST_ALE;
              xapc_pkg::XAPC_TGT_FLASH: state_q <= ST_DONE; // Flash elsewhere
            endcase
          end
        end
        ST_RAM: state_q <= ST_DONE;
        ST_FIFO: begin
          // Least wait plus the bridge ack; covers the usb_clock crossing
          if (cnt_q != FIFO_LAST) begin
            cnt_q <= cnt_q + 3'h1;
          end else if (fifo_ack_i) begin
            state_q <= ST_DONE;
          end
        end
        ST_ALE, ST_HOLD: begin
          if (cnt_q == ale_last) begin
            cnt_q   <= 3'h0;
            state_q <= (state_q == ST_ALE) ? ST_HOLD : ST_STRB;
          end else begin
            cnt_q <= cnt_q + 3'h1;
          end
        end
        ST_STRB: begin
          if (cnt_q == STRB_LAST) begin
            state_q <= ST_DONE;
          end else begin
            cnt_q <= cnt_q + 3'h1;
          end
        end
        ST_DONE: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Request capture
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      addr_q  <= 16'h0000;
      write_q <= 1'b0;
      wdata_q <= 8'h00_00;
      tgt_q   <= xapc_pkg::XAPC_TGT_RAM;
    end else if (ce_i && state_q == ST_IDLE && req_i) begin
      addr_q  <= req_addr;
      write_q <= req_data_i.write;
      wdata_q <= req_data_i.wdata;
      tgt_q   <= req_tgt;
    end
  end

  // Read result from whichever memory served the move
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_q <= 8'h00_00;
    end else if (ce_i && !write_q) begin
      if (state_q == ST_RAM) begin
        rdata_q <= ram_rdata_i;
      end else if (state_q == ST_FIFO && cnt_q == FIFO_LAST && fifo_ack_i) begin
        rdata_q <= fifo_rdata_i;
      end else if (state_q == ST_STRB && cnt_q == STRB_LAST) begin
        rdata_q <= pin_i.ad; // Sampled at end of the read strobe
      end
    end
  end

  // ========================================================================
  // Memory side strobes
  assign ram_req_o    = (state_q == ST_RAM);
  assign ram_we_o     = write_q;
  assign ram_addr_o   = addr_q;
  assign ram_wdata_o  = wdata_q;
  assign fifo_req_o   = (state_q == ST_FIFO);
  assign fifo_we_o    = write_q;
  assign fifo_addr_o  = addr_q[9:0];
  assign fifo_wdata_o = wdata_q;

  // ========================================================================
  // Pin ownership; mode drivers stay with port mode registers
  assign claimed = (state_q == ST_ALE) || (state_q == ST_HOLD) ||
                   (state_q == ST_STRB);

  always_comb begin
    pin_o    = port_latch_i;
    pin_oe_o = port_oe_i;
    if (claimed) begin
      pin_o.ahi   = addr_q[15:8];
      // Pins of the unused bus style stay with the latch and crossbar
      pin_o.alo   = nonmux ? addr_q[7:0] : port_latch_i.alo;
      pin_o.ale   = nonmux ? port_latch_i.ale : (state_q == ST_ALE);
      pin_o.rd_n  = !(state_q == ST_STRB && !write_q);
      pin_o.wr_n  = !(state_q == ST_STRB && write_q);
      pin_o.ad    = (state_q == ST_ALE) ? addr_q[7:0] : wdata_q;
      pin_oe_o.ahi  = 8'h00_FF;
      pin_oe_o.alo  = nonmux ? 8'h00_FF : port_oe_i.alo;
      pin_oe_o.ale  = nonmux ? port_oe_i.ale : 1'b1;
      pin_oe_o.rd_n = 1'b1;
      pin_oe_o.wr_n = 1'b1;
      // Read data pins float except while the muxed address is shown
      pin_oe_o.ad = (write_q || state_q == ST_ALE) ? 8'h00_FF
                                                   : 8'h00_00;
    end
  end

  assign busy_o      = (state_q != ST_IDLE);
  assign done_o      = (state_q == ST_DONE);
  assign rdata_o     = rdata_q;
  assign target_o    = tgt_q;
  assign sfr_rdata_o = sfr_rdata_q;

  // ========================================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_ale_phase;
    state_q == ST_ALE && pin_o.ale && pin_o.ad == addr_q[7:0];
  endsequence
  sequence s_data_phase;
    state_q != ST_ALE && !pin_o.ale;
  endsequence

  chk_ptr_addr: assert property (ce_i && state_q == ST_IDLE && req_i &&
    req_data_i.ptr_form |=> addr_q == $past(dp_q))
    else $error("pointer move address wrong");
  chk_idx_addr: assert property (ce_i && state_q == ST_IDLE && req_i &&
    !req_data_i.ptr_form
    |=> addr_q == {$past(page_q), $past(req_data_i.index)})
    else $error("indexed move address wrong");
  chk_fifo_win: assert property (ce_i && state_q == ST_IDLE && req_i &&
    !req_data_i.flash && cfg_q[6] && req_addr[15:10] == 6'h01
    |=> state_q == ST_FIFO)
    else $error("window address not sent to fifo");
  chk_fifo_only: assert property ((state_q == ST_RAM || claimed)
    |-> !(cfg_q[6] && addr_q[15:10] == 6'h01))
    else $error("window address reached ordinary memory");
  chk_fifo_slow: assert property ($rose(state_q == ST_FIFO)
    |=> state_q == ST_FIFO)
    else $error("fifo move not longer than ram move");
  chk_pin_release: assert property (state_q == ST_DONE
    |-> pin_o == port_latch_i && pin_oe_o == port_oe_i)
    else $error("pins held after move");
  chk_read_float: assert property (state_q == ST_STRB && !write_q
    |-> pin_oe_o.ad == 8'h00_00)
    else $error("data driver on during read");
  chk_ale_order: assert property (s_ale_phase ##1 state_q != ST_ALE
    |-> s_data_phase)
    else $error("latch strobe order wrong");
  chk_strb_end: assert property (ce_i && state_q == ST_STRB &&
    cnt_q == STRB_LAST |=> !claimed)
    else $error("pins not released at completion");

endmodule
`default_nettype wire

// File: rtl/xapc_pkg.sv
`default_nettype none
// ==========================================================================
// Shared constants and carriers of the data-space access port
package xapc_pkg;

  // ========================================================================
  // Special register addresses
  localparam logic [7:0] ADDR_PAGE   = 8'h00_AA; // Page register
  localparam logic [7:0] ADDR_CFG    = 8'h00_85; // Port configuration
  localparam logic [7:0] ADDR_DP_LO  = 8'h00_82; // Pointer low byte
  localparam logic [7:0] ADDR_DP_HI  = 8'h00_83; // Pointer high byte

  // ========================================================================
  // Reset values
  localparam logic [7:0] RST_PAGE    = 8'h00_00;
  localparam logic [7:0] RST_CFG     = 8'h00_03;
  localparam logic [15:0] RST_DP     = 16'h0000;

  // ========================================================================
  // Configuration fields
  localparam int CFG_FIFO_EN_BIT     = 6;  // fifo_window_enable
  localparam int CFG_NONMUX_BIT      = 4;  // Separate address/data pins
  localparam int CFG_MODE_LSB        = 2;  // Two mode bits
  localparam int CFG_ALE_LSB         = 0;  // Two strobe-width bits
  localparam logic [7:0] CFG_WMASK   = 8'h00_5F; // Bits 7 and 5 unused

  // ========================================================================
  // Memory map
  localparam logic [15:0] FIFO_LO    = 16'h0400;
  localparam logic [15:0] FIFO_HI    = 16'h07FF;

  // ========================================================================
  // Timing
  localparam int CLK_PERIOD_NS       = 100;  // system_clock, 10 MHz
  localparam int RAM_CYCLES          = 1;    // On-chip access length
  localparam int STROBE_CYCLES_DEF   = 2;    // Off-chip strobe width
  localparam int FIFO_MIN_CYCLES_DEF = 2;    // Least wait on fifo RAM

  // ========================================================================
  // Memory modes
  typedef enum logic [1:0] {
    XAPC_MODE_ONCHIP = 2'b00,
    XAPC_MODE_SPLIT  = 2'b01,
    XAPC_MODE_BANK   = 2'b10,
    XAPC_MODE_OFF    = 2'b11
  } xapc_mode_e;

  // Access targets
  typedef enum logic [1:0] {
    XAPC_TGT_RAM   = 2'b00,
    XAPC_TGT_FIFO  = 2'b01,
    XAPC_TGT_OFF   = 2'b10,
    XAPC_TGT_FLASH = 2'b11
  } xapc_tgt_e;

  // Pin group of the external_memory_port
  typedef struct packed {
    logic [7:0] ad;   // Data, or muxed low address and data
    logic [7:0] alo;  // Separate low address
    logic [7:0] ahi;  // High address
    logic       ale;  // Address latch strobe, high active
    logic       rd_n; // Read strobe
    logic       wr_n; // Write strobe
  } xapc_pins_s;

  // Core request
  typedef struct packed {
    logic       ptr_form; // 1: data_pointer, 0: page plus index
    logic       write;
    logic       flash;    // Move aimed at flash programming
    logic [7:0] index;    // R0 or
    logic [7:0] wdata;
  } xapc_req_s;

endpackage
`default_nettype wire

// File: verif/tb.sv
`default_nettype none
// ==========================================================================
// Bench: drives moves, models both RAMs, checks against noted results
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [1:0] tgt;
    logic       rd;
    logic [7:0] dat;
  } xapc_exp_s;
  localparam int STRB = 2;
  localparam int FMIN = 2;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, ce_i = 1'b1, slow = 1'b0;
  logic sfr_wr_i = 1'b0, sfr_rd_i = 1'b0, req_i = 1'b0, fifo_ack_i = 1'b0;
  logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, fifo_rdata_i = 8'h00;
  logic [7:0] sfr_rdata_o, rdata_o, ram_rdata_i, ram_wdata_o, fifo_wdata_o;
  logic busy_o, done_o, ram_req_o, ram_we_o, fifo_req_o, fifo_we_o;
  logic [1:0] target_o, dly_q = 2'h0;
  logic [15:0] ram_addr_o;
  logic [9:0] fifo_addr_o;
  xapc_pkg::xapc_req_s req_data_i = '0;
  xapc_pkg::xapc_pins_s port_latch_i = '1, port_oe_i = '0;
  xapc_pkg::xapc_pins_s pin_i, pin_o, pin_oe_o;
  logic [7:0] ram_m [0:4095];
  logic [7:0] fifo_m [0:1023];
  logic [7:0] refm [logic [17:0]];
  logic [7:0] cfg = 8'h03;
  logic [1:0] cur_tgt = 2'h0;
  logic rd_pend = 1'b0;
  xapc_exp_s q_mv [$];
  logic [7:0] q_sfr [$];
  int mismatches = 0;
  int n_compared = 0;
  // ==========================================================================
  // Design and the off-chip memory on its port
  xapc_ctrl #(.STROBE_CYCLES(STRB), .FIFO_MIN_CYCLES(FMIN)) i_dut (
    .clk_i, .sys_rst_i, .ce_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i,
    .sfr_wdata_i, .sfr_rdata_o, .req_i, .req_data_i, .busy_o, .done_o,
    .rdata_o, .target_o, .ram_req_o, .ram_we_o, .ram_addr_o, .ram_wdata_o,
    .ram_rdata_i, .fifo_req_o, .fifo_we_o, .fifo_addr_o, .fifo_wdata_o,
    .fifo_ack_i, .fifo_rdata_i, .port_latch_i, .port_oe_i, .pin_i, .pin_o,
    .pin_oe_o
  );
  xapc_xmem i_mem (.clk_i, .slow_i(slow), .mux_i(!cfg[4]),
    .drv_i(pin_o), .oe_i(pin_oe_o),
    .latch_i(port_latch_i), .wire_o(pin_i));
  // Clock, 100 ns period
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  // On-chip RAM answers in the cycle of the request
  assign ram_rdata_i = ram_m[ram_addr_o[11:0]];
  always @(posedge clk_i) begin
    if (ram_req_o && ram_we_o) ram_m[ram_addr_o[11:0]] <= ram_wdata_o;
  end
  // Fifo RAM acks after a random wait, as a slower domain would
  always @(posedge clk_i) begin
    if (!fifo_req_o) dly_q <= 2'($urandom_range(3));
    else if (dly_q != 2'h0) dly_q <= dly_q - 2'h1;
    fifo_ack_i <= fifo_req_o && dly_q == 2'h0;
    fifo_rdata_i <= fifo_m[fifo_addr_o];
    if (fifo_req_o && fifo_we_o && fifo_ack_i) begin
      fifo_m[fifo_addr_o] <= fifo_wdata_o;
    end
  end
  // ==========================================================================
  // Checking
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Oldest note is taken off whenever a result shows
  always @(posedge clk_i) begin
    xapc_exp_s e;
    if (!sys_rst_i) begin
      if (rd_pend) chk("sfr_rdata", q_sfr.pop_front(), sfr_rdata_o);
      if (done_o === 1'b1) begin
        e = q_mv.pop_front();
        chk("target", e.tgt, target_o);
        if (e.rd) chk("rdata", e.dat, rdata_o);
      end
      if (busy_o !== 1'b1 || done_o === 1'b1 || cur_tgt != 2'h2) begin
        chk("pin_oe", port_oe_i, pin_oe_o);
        chk("pin_o", port_latch_i, pin_o);
      end
      if (pin_oe_o.rd_n && !pin_o.rd_n) chk("ad_oe", 8'h00, pin_oe_o.ad);
    end
    rd_pend <= sfr_rd_i && ce_i;
  end
  // ==========================================================================
  // Drivers
  task automatic sfr(input logic rd, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    sfr_rd_i <= rd;
    sfr_wr_i <= !rd;
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    if (rd) q_sfr.push_back(d);
    @(posedge clk_i);
    sfr_rd_i <= 1'b0;
    sfr_wr_i <= 1'b0;
  endtask
  // Bus choice, memory mode and timing go in one configuration write
  task automatic setcfg(input logic [7:0] c);
    cfg = c;
    sfr(1'b0, xapc_pkg::ADDR_CFG, c);
  endtask
  function automatic logic [1:0] tgt_of(input logic [15:0] a, input logic fl);
    if (fl) return 2'h3;
    if (cfg[6] && a >= 16'h0400 && a <= 16'h07FF) return 2'h1;
    case (cfg[3:2])
      2'b00: return 2'h0;
      2'b11: return 2'h2;
      default: return (a < 16'h1000) ? 2'h0 : 2'h2;
    endcase
  endfunction
  // One move: address set up, request for one cycle, bounded wait
  task automatic mv(input logic ptr, wr, fl, input logic [15:0] a);
    xapc_exp_s e;
    logic [7:0] d;
    int n;
    int lt;
    d = 8'($urandom);
    e.tgt = tgt_of(a, fl);
    e.rd = !wr && !fl;
    e.dat = refm.exists({e.tgt, a}) ? refm[{e.tgt, a}] : 8'h00;
    if (ptr) begin
      sfr(1'b0, xapc_pkg::ADDR_DP_HI, a[15:8]);
      sfr(1'b0, xapc_pkg::ADDR_DP_LO, a[7:0]);
    end else begin
      sfr(1'b0, xapc_pkg::ADDR_PAGE, a[15:8]);
    end
    if (wr && !fl) refm[{e.tgt, a}] = d;
    q_mv.push_back(e);
    cur_tgt = e.tgt;
    @(posedge clk_i);
    chk("busy_idle", 0, busy_o);
    req_i <= 1'b1;
    req_data_i <= '{ptr, wr, fl, a[7:0], d};
    // Strobes enabled in the crossbar, parked high by push-pull drivers
    port_oe_i <= 27'($urandom) | 27'h7;
    @(posedge clk_i);
    req_i <= 1'b0;
    n = 0;
    while (done_o !== 1'b1 && n < 40) begin
      @(posedge clk_i);
      n++;
      chk("busy_o", 1, busy_o);
    end
    if (e.tgt == 2'h3) lt = 1; // Flash moves go straight to done
    else if (e.tgt != 2'h2) lt = 2;
    else lt = cfg[4] ? STRB + 1 : 2 * (cfg[1:0] + 1) + STRB + 1;
    if (e.tgt == 2'h1) chk("fifo_lat", 1, n > 2);
    else chk("latency", lt, n);
  endtask
  task automatic done_t(input string nm);
    $display("test %s done", nm);
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ==========================================================================
  // Tests
  initial begin
    logic [15:0] a;
    logic [7:0] cl [7];
    logic [15:0] fa [5];
    cl = '{8'h1C, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h14, 8'h18};
    fa = '{16'h03FF, 16'h0400, 16'h0500, 16'h07FF, 16'h0800};
    void'($urandom(32'hee64_fdbe));
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    // Reset values, byte independence, unused bits, unmapped address
    sfr(1'b1, xapc_pkg::ADDR_PAGE, 8'h00);
    sfr(1'b1, xapc_pkg::ADDR_CFG, 8'h03);
    sfr(1'b1, xapc_pkg::ADDR_DP_HI, 8'h00);
    sfr(1'b0, xapc_pkg::ADDR_DP_HI, 8'hA5);
    sfr(1'b1, xapc_pkg::ADDR_DP_LO, 8'h00);
    sfr(1'b1, xapc_pkg::ADDR_DP_HI, 8'hA5);
    sfr(1'b0, 8'h90, 8'hFF);
    sfr(1'b1, 8'h90, 8'h00);
    sfr(1'b0, xapc_pkg::ADDR_CFG, 8'hFF);
    sfr(1'b1, xapc_pkg::ADDR_CFG, 8'h5F);
    done_t("registers");
    // On-chip moves, each random-address byte written by one form and read by the other
    setcfg(8'h03);
    for (int i = 0; i < 8; i++) begin
      a = 16'($urandom_range(4095));
      mv(i[0], 1'b1, 1'b0, a);
      mv(!i[0], 1'b0, 1'b0, a);
    end
    mv(1'b0, 1'b1, 1'b0, 16'h0FFF);
    mv(1'b0, 1'b0, 1'b0, 16'h0FFF);
    mv(1'b1, 1'b1, 1'b0, 16'h0500);
    done_t("onchip");
    // Fifo window edges, then the shadowed RAM byte comes back
    setcfg(8'h43);
    foreach (fa[i]) begin
      mv(1'b1, 1'b1, 1'b0, fa[i]);
      mv(1'b0, 1'b0, 1'b0, fa[i]);
    end
    setcfg(8'h03);
    mv(1'b1, 1'b0, 1'b0, 16'h0500);
    done_t("fifo");
    // Off-chip and split modes, every latch width, prompt and slow memory
    foreach (cl[i]) begin
      setcfg(cl[i]);
      slow <= 1'($urandom);
      a = 16'($urandom);
      mv(1'b1, 1'b1, 1'b0, a);
      mv(1'b0, 1'b0, 1'b0, a);
      mv(1'b0, 1'b1, 1'b0, 16'h0FFF);
      mv(1'b1, 1'b0, 1'b0, 16'h0FFF);
      mv(1'b0, 1'b1, 1'b0, 16'h1000);
      mv(1'b1, 1'b0, 1'b0, 16'h1000);
    end
    done_t("offchip");
    // Flash moves touch no memory and no pins
    setcfg(8'h03);
    mv(1'b1, 1'b1, 1'b1, 16'h2345);
    mv(1'b0, 1'b0, 1'b1, 16'h2345);
    done_t("flash");
    finish_test();
  end
  // Watchdog: the whole run needs well under this many cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    finish_test();
  end
endmodule
`default_nettype wire

// File: verif/xapc_xmem.sv
`default_nettype none
// ==========================================================================
// Off-chip byte memory hanging on the external port pins
module xapc_xmem (
  input  wire logic                 clk_i,   // system_clock
  input  wire logic                 slow_i,  // Read data one cycle late
  input  wire logic                 mux_i,   // Board uses the address latch
  input  wire xapc_pkg::xapc_pins_s drv_i,   // Design drive values
  input  wire xapc_pkg::xapc_pins_s oe_i,    // Design drive enables
  input  wire xapc_pkg::xapc_pins_s latch_i, // Parked port levels
  output xapc_pkg::xapc_pins_s      wire_o   // Resolved pin levels
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  mem [0:65535];
  logic [7:0]  lo_q = 8'h00;
  logic [7:0]  last_q = 8'h00;
  logic        age_q = 1'b0;
  logic [15:0] addr;
  logic        rd;
  logic        wr;
  // Strobes count only while the design claims them
  assign rd = oe_i.rd_n && !drv_i.rd_n;
  assign wr = oe_i.wr_n && !drv_i.wr_n;
  assign addr = {drv_i.ahi, mux_i ? lo_q : drv_i.alo};
  // Unclaimed pins rest at the latch; a free data bus keeps toggling
  always_comb begin
    wire_o = (drv_i & oe_i) | (latch_i & ~oe_i);
    if (oe_i.ad == 8'h00) begin
      wire_o.ad = (rd && (age_q || !slow_i)) ? mem[addr] : ~last_q;
    end
  end
  // Low address caught while the latch strobe is high; store on write
  always @(posedge clk_i) begin
    if (mux_i && oe_i.ale && drv_i.ale) lo_q <= drv_i.ad;
    if (wr) mem[addr] <= drv_i.ad;
    age_q <= rd;
    last_q <= wire_o.ad;
  end
endmodule
`default_nettype wire
